// ### dv/ccir_host_model.sv
// Host-side model driving the byte register port of the register bank
`timescale 1ns/100ps
`default_nettype none

module ccir_host_model (
    input wire logic clk,
    output logic [7:0] regAddr,
    output logic regWrite,
    output logic [7:0] regWriteData,
    output logic regRead,
    input wire logic [7:0] regReadData
);
    // ----------------------------------------
    // Idle bus state
    // ----------------------------------------
    initial begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regWriteData = 8'h00;
        regRead = 1'b0;
    end

    // One byte write; the 7-bit device address is already resolved upstream
    task automatic write_reg(input logic [7:0] ofs, input logic [7:0] val);
        regAddr = ofs;
        regWriteData = val;
        regWrite = 1'b1;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
        // Released lines show the inverse so stale values never look valid
        regAddr = ~ofs;
        regWriteData = ~val;
        // One idle edge so a following call never re-raises the strobe in this time step
        @(posedge clk);
        #1;
    endtask : write_reg

    // One byte read; data is registered at the strobe edge
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] val);
        regAddr = ofs;
        regRead = 1'b1;
        @(posedge clk);
        #1;
        regRead = 1'b0;
        regAddr = ~ofs;
        val = regReadData;
        // One idle edge so a following call never re-raises the strobe in this time step
        @(posedge clk);
        #1;
    endtask : read_reg
endmodule : ccir_host_model

`default_nettype wire

// ### dv/charger_ctrl_interrupt_regs_test.sv
// Self-checking testbench for the charger control and interrupt register bank
`timescale 1ns/100ps
`default_nettype none

module charger_ctrl_interrupt_regs_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic offState = 1'b0;
    logic registerReset = 1'b0;
    logic otgModeEntry = 1'b0;
    logic chargeModeEntry = 1'b0;
    logic timerResetEvent = 1'b0;
    logic watchdogExpiry = 1'b0;
    logic usbTimerExpiry = 1'b0;
    logic chargeTimerExpiry = 1'b0;
    logic globalIntMask = 1'b1;
    logic [3:0] batteryTempCond = 4'h0;
    ccir_pkg::ccir_status_t statusCond = '0;
    ccir_pkg::ccir_charger_one_t chargerOneCond = '0;
    ccir_pkg::ccir_boost_t boostCond = '0;
    ccir_pkg::ccir_sense_t senseLive = '0;
    logic [7:0] regAddr;
    logic regWrite;
    logic [7:0] regWriteData;
    logic regRead;
    logic [7:0] regReadData;
    ccir_pkg::ccir_control_two_t controlTwo;
    logic statusPendingSummary;
    logic faultPendingSummary;
    logic interruptActive;
    logic [7:0] rd;
    int failures = 0;
    int samplesChecked = 0;

    // ----------------------------------------
    // Clock, design and host
    // ----------------------------------------
    always #5 clk = ~clk;

    ccir_charger_ctrl_interrupt_regs dut (.clk(clk), .reset(reset), .offState(offState),
        .registerReset(registerReset), .otgModeEntry(otgModeEntry),
        .chargeModeEntry(chargeModeEntry), .timerResetEvent(timerResetEvent),
        .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData),
        .regRead(regRead), .regReadData(regReadData), .statusCond(statusCond),
        .chargerOneCond(chargerOneCond), .batteryTempCond(batteryTempCond),
        .watchdogExpiry(watchdogExpiry), .usbTimerExpiry(usbTimerExpiry),
        .chargeTimerExpiry(chargeTimerExpiry), .boostCond(boostCond), .senseLive(senseLive),
        .globalIntMask(globalIntMask), .controlTwo(controlTwo),
        .statusPendingSummary(statusPendingSummary),
        .faultPendingSummary(faultPendingSummary), .interruptActive(interruptActive));

    ccir_host_model host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite),
        .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Advance to just after the next rising edge so inputs never race it
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        if (failures == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // Hang guard; the sequence needs fewer than a hundred cycles
    initial begin
        #50000;
        failures++;
        final_report();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        #1;
        reset = 1'b0;
        check("control_two port", controlTwo, 8'h16);
        host.read_reg(8'h02, rd);
        check("control_two reset", rd, 8'h16);
        host.write_reg(8'h02, 8'he9);
        check("control_two port", controlTwo, 8'he9);
        host.read_reg(8'h02, rd);
        check("control_two readback", rd, 8'he9);
        // OTG entry restores defaults but keeps the transceiver supply bit
        otgModeEntry = 1'b1;
        step();
        otgModeEntry = 1'b0;
        host.read_reg(8'h02, rd);
        check("control_two after otg", rd, 8'h06);
        host.write_reg(8'h02, 8'hff);
        host.write_reg(8'h03, 8'h00);
        host.read_reg(8'h02, rd);
        check("control_two all ones", rd, 8'hff);
        host.read_reg(8'h08, rd);
        check("unmapped read", rd, 8'h00);
        otgModeEntry = 1'b1;
        step();
        otgModeEntry = 1'b0;
        check("control_two otg keep", controlTwo, 8'h16);
        check("status flags before", {7'h0, statusPendingSummary}, 8'h00);
        // Status flags, summary and global mask
        statusCond = 6'h3f;
        step();
        statusCond = 6'h00;
        check("status pending", {7'h0, statusPendingSummary}, 8'h01);
        check("masked irq", {7'h0, interruptActive}, 8'h00);
        globalIntMask = 1'b0;
        #1;
        check("unmasked irq", {7'h0, interruptActive}, 8'h01);
        host.read_reg(8'h03, rd);
        check("status flags", rd, 8'h3f);
        host.read_reg(8'h03, rd);
        check("status cleared", rd, 8'h00);
        statusCond = 6'h3f;
        step();
        statusCond = 6'h00;
        otgModeEntry = 1'b1;
        step();
        otgModeEntry = 1'b0;
        host.read_reg(8'h03, rd);
        check("status after otg", rd, 8'h3c);
        check("status idle", {7'h0, statusPendingSummary}, 8'h00);
        // Charger flags and cross summaries
        chargerOneCond = 4'hf;
        batteryTempCond = 4'ha;
        watchdogExpiry = 1'b1;
        usbTimerExpiry = 1'b1;
        chargeTimerExpiry = 1'b1;
        step();
        chargerOneCond = 4'h0;
        batteryTempCond = 4'h0;
        watchdogExpiry = 1'b0;
        usbTimerExpiry = 1'b0;
        chargeTimerExpiry = 1'b0;
        check("fault pending", {7'h0, faultPendingSummary}, 8'h01);
        host.read_reg(8'h05, rd);
        check("charger two", rd, 8'haf);
        host.read_reg(8'h04, rd);
        check("charger one", rd, 8'h1e);
        // A persisting condition survives the read
        chargerOneCond = 4'h8;
        step();
        host.read_reg(8'h04, rd);
        check("detect held", rd, 8'h10);
        chargerOneCond = 4'hc;
        step();
        host.read_reg(8'h04, rd);
        check("overvoltage held", rd, 8'h18);
        chargerOneCond = 4'h3;
        step();
        chargerOneCond = 4'h0;
        host.read_reg(8'h04, rd);
        check("removal overvolt", rd, 8'h1e);
        host.read_reg(8'h04, rd);
        check("charger one clear", rd, 8'h00);
        // Timer reset clears expiry flags
        watchdogExpiry = 1'b1;
        usbTimerExpiry = 1'b1;
        chargeTimerExpiry = 1'b1;
        step();
        watchdogExpiry = 1'b0;
        usbTimerExpiry = 1'b0;
        chargeTimerExpiry = 1'b0;
        timerResetEvent = 1'b1;
        step();
        timerResetEvent = 1'b0;
        host.read_reg(8'h05, rd);
        check("timer reset", rd, 8'h00);
        // Boost flags and charge mode entry
        boostCond = 3'h7;
        step();
        boostCond = 3'h0;
        host.read_reg(8'h06, rd);
        check("boost flags", rd, 8'h07);
        boostCond = 3'h5;
        step();
        boostCond = 3'h0;
        chargeModeEntry = 1'b1;
        step();
        chargeModeEntry = 1'b0;
        host.read_reg(8'h06, rd);
        check("boost on charge", rd, 8'h00);
        // Live sense bits
        senseLive = 7'h55;
        host.read_reg(8'h07, rd);
        check("sense upper", rd, 8'haa);
        senseLive = 7'h2a;
        host.read_reg(8'h07, rd);
        check("sense lower", rd, 8'h54);
        // Software reset and off state restore defaults
        host.write_reg(8'h02, 8'ha1);
        boostCond = 3'h2;
        step();
        boostCond = 3'h0;
        registerReset = 1'b1;
        step();
        registerReset = 1'b0;
        host.read_reg(8'h06, rd);
        check("boost after sw reset", rd, 8'h00);
        host.read_reg(8'h02, rd);
        check("control_two after sw reset", rd, 8'h16);
        host.write_reg(8'h02, 8'ha1);
        offState = 1'b1;
        step();
        offState = 1'b0;
        check("control_two after off", controlTwo, 8'h16);
        final_report();
    end
endmodule : charger_ctrl_interrupt_regs_test

`default_nettype wire

// ### rtl/ccir_charger_ctrl_interrupt_regs.sv
// Second control register, interrupt flag registers and input sense register
`timescale 1ns/100ps
`default_nettype none

module ccir_charger_ctrl_interrupt_regs (
    input wire logic clk,
    input wire logic reset,
    // Device-level reset sources, one-cycle pulses or levels
    input wire logic offState,
    input wire logic registerReset,
    input wire logic otgModeEntry,
    input wire logic chargeModeEntry,
    input wire logic timerResetEvent,
    // Byte register port from the I2C slave engine
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWriteData,
    input wire logic regRead,
    output logic [7:0] regReadData,
    // Condition levels and expiry pulses
    input wire ccir_pkg::ccir_status_t statusCond,
    input wire ccir_pkg::ccir_charger_one_t chargerOneCond,
    input wire logic [3:0] batteryTempCond,
    input wire logic watchdogExpiry,
    input wire logic usbTimerExpiry,
    input wire logic chargeTimerExpiry,
    input wire ccir_pkg::ccir_boost_t boostCond,
    input wire ccir_pkg::ccir_sense_t senseLive,
    // Global mask bit from the first control register
    input wire logic globalIntMask,
    // Control outputs and summaries
    output ccir_pkg::ccir_control_two_t controlTwo,
    output logic statusPendingSummary,
    output logic faultPendingSummary,
    output logic interruptActive
);

    // ------------------------------------------------------------
    // Common decode
    // ------------------------------------------------------------
    // Power-on, off state and software reset all restore defaults
    logic fullReset;
    assign fullReset = reset | offState | registerReset;

    function automatic logic hostReads(input logic rd, input logic [7:0] a,
                                       input logic [7:0] ofs);
        hostReads = rd && (a == ofs);
    endfunction : hostReads

    logic readStatus;
    logic readChargerOne;
    logic readChargerTwo;
    logic readBoost;
    assign readStatus = hostReads(regRead, regAddr, ccir_pkg::CCIR_OFS_STATUS_INT);
    assign readChargerOne = hostReads(regRead, regAddr, ccir_pkg::CCIR_OFS_CHARGER_ONE);
    assign readChargerTwo = hostReads(regRead, regAddr, ccir_pkg::CCIR_OFS_CHARGER_TWO);
    assign readBoost = hostReads(regRead, regAddr, ccir_pkg::CCIR_OFS_BOOST_INT);

    // ------------------------------------------------------------
    // Control register two
    // ------------------------------------------------------------
    // OTG entry beats a host write in the same cycle so the mode change
    // always lands on defaults, except that the transceiver supply bit is kept
    always_ff @(posedge clk) begin
        if (fullReset) begin
            controlTwo <= ccir_pkg::CCIR_CONTROL_TWO_RESET;
        end else if (otgModeEntry) begin
            controlTwo <= (controlTwo & ccir_pkg::CCIR_CONTROL_TWO_OTG_KEEP)
                | (ccir_pkg::CCIR_CONTROL_TWO_RESET & ~ccir_pkg::CCIR_CONTROL_TWO_OTG_KEEP);
        end else if (regWrite && regAddr == ccir_pkg::CCIR_OFS_CONTROL_TWO) begin
            controlTwo <= ccir_pkg::ccir_control_two_t'(regWriteData);
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------
    // Set wins over read clear, so a persisting condition is re-raised
    function automatic logic [6:0] stickyNext(input logic [6:0] cur,
                                              input logic [6:0] set,
                                              input logic clr);
        stickyNext = set | (cur & {7{~clr}});
    endfunction : stickyNext

    ccir_pkg::ccir_status_t statusFlags;
    ccir_pkg::ccir_charger_one_t chargerOneFlags;
    ccir_pkg::ccir_charger_two_t chargerTwoFlags;
    ccir_pkg::ccir_boost_t boostFlags;

    // Status flags: die temperature kept through OTG entry, range bits not
    always_ff @(posedge clk) begin
        if (fullReset) begin
            statusFlags <= '0;
        end else begin
            statusFlags <= 6'(stickyNext(7'(statusFlags), 7'(statusCond), readStatus));
            if (otgModeEntry) begin
                statusFlags.extendedRange <= 1'b0;
                statusFlags.usbRange <= 1'b0;
            end
        end
    end

    // Charger register one flags
    always_ff @(posedge clk) begin
        if (fullReset || otgModeEntry) begin
            chargerOneFlags <= '0;
        end else begin
            chargerOneFlags <= 4'(stickyNext(7'(chargerOneFlags), 7'(chargerOneCond),
                readChargerOne));
        end
    end

    // Charger register two: temperature bands and timer expiry flags
    always_ff @(posedge clk) begin
        if (fullReset || otgModeEntry) begin
            chargerTwoFlags <= '0;
        end else begin
            chargerTwoFlags.batteryTemp <= 4'(stickyNext(7'(chargerTwoFlags.batteryTemp),
                7'(batteryTempCond), readChargerTwo));
            // A timer reset clears the expiry flags but a fresh expiry still wins
            chargerTwoFlags.watchdogExpired <= watchdogExpiry | (chargerTwoFlags.watchdogExpired
                & ~readChargerTwo & ~timerResetEvent);
            chargerTwoFlags.usbTimerExpired <= usbTimerExpiry | (chargerTwoFlags.usbTimerExpired
                & ~readChargerTwo & ~timerResetEvent);
            chargerTwoFlags.chargeTimerExpired <= chargeTimerExpiry
                | (chargerTwoFlags.chargeTimerExpired & ~readChargerTwo
                & ~timerResetEvent);
        end
    end

    // Boost flags are cleared on charge mode entry instead of OTG entry
    always_ff @(posedge clk) begin
        if (fullReset || chargeModeEntry) begin
            boostFlags <= '0;
        end else begin
            boostFlags <= 3'(stickyNext(7'(boostFlags), 7'(boostCond), readBoost));
        end
    end

    // ------------------------------------------------------------
    // Summaries and interrupt gate
    // ------------------------------------------------------------
    logic chargerOnePending;
    logic chargerTwoPending;
    assign chargerOnePending = |chargerOneFlags;
    assign chargerTwoPending = |chargerTwoFlags;

    // Handshake-style outputs stay combinational from the flag flops
    assign statusPendingSummary = |statusFlags;
    assign faultPendingSummary = chargerOnePending | chargerTwoPending | (|boostFlags);
    assign interruptActive = ~globalIntMask
        & (statusPendingSummary | faultPendingSummary);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Captured on the read strobe, using flag values before the clear
    logic [7:0] next_regReadData;
    always_comb begin
        unique case (regAddr)
            ccir_pkg::CCIR_OFS_CONTROL_TWO: next_regReadData = controlTwo;
            ccir_pkg::CCIR_OFS_STATUS_INT:
                next_regReadData = {ccir_pkg::CCIR_PAD_TWO, statusFlags};
            ccir_pkg::CCIR_OFS_CHARGER_ONE:
                next_regReadData = {ccir_pkg::CCIR_PAD_THREE, chargerOneFlags,
                    chargerTwoPending};
            ccir_pkg::CCIR_OFS_CHARGER_TWO:
                next_regReadData = {chargerTwoFlags, chargerOnePending};
            ccir_pkg::CCIR_OFS_BOOST_INT:
                next_regReadData = {ccir_pkg::CCIR_PAD_FIVE, boostFlags};
            ccir_pkg::CCIR_OFS_INPUT_SENSE:
                next_regReadData = {senseLive, 1'b0};
            default: next_regReadData = ccir_pkg::CCIR_READ_ZERO;
        endcase
    end

    // Sense register is never reset; only the read latch is
    always_ff @(posedge clk) begin
        if (reset) begin
            regReadData <= ccir_pkg::CCIR_READ_ZERO;
        end else if (regRead) begin
            regReadData <= next_regReadData;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence readOfBoostQuiet;
        readBoost && !(|boostCond) && !fullReset && !chargeModeEntry;
    endsequence

    chk_control_two_reset_value: assert property (fullReset |=> controlTwo == ccir_pkg::CCIR_CONTROL_TWO_RESET)
        else $error("Control two not at default after reset source");
    chk_otg_keeps_trans: assert property (otgModeEntry && !fullReset
        |=> controlTwo.transceiver_supply_on == $past(controlTwo.transceiver_supply_on)
        && controlTwo.watchdog_disable == 1'b0 && controlTwo.input_limit_enable)
        else $error("OTG entry mishandled control two");
    chk_control_two_write: assert property (regWrite && regAddr == ccir_pkg::CCIR_OFS_CONTROL_TWO
        && !fullReset
        && !otgModeEntry |=> controlTwo == $past(regWriteData))
        else $error("Control two write not stored");
    chk_boost_read_clear: assert property (readOfBoostQuiet ##1 !(|boostCond)
        |-> boostFlags == 3'h0)
        else $error("Boost flags not cleared by read");
    chk_set_beats_clear: assert property (readChargerOne && chargerOneCond.inputOvervoltage
        && !fullReset && !otgModeEntry |=> chargerOneFlags.inputOvervoltage)
        else $error("Persisting input overvoltage lost on read");
    chk_timer_reset_clr: assert property (timerResetEvent && !watchdogExpiry
        |=> !chargerTwoFlags.watchdogExpired)
        else $error("Timer reset did not clear watchdog flag");
    chk_charge_mode_clr: assert property (chargeModeEntry |=> boostFlags == 3'h0)
        else $error("Charge mode entry did not clear boost flags");
    chk_mask_gate: assert property (globalIntMask |-> !interruptActive)
        else $error("Interrupt active while globally masked");
    chk_summary_read: assert property (readChargerOne
        |=> regReadData[0] == $past(chargerTwoPending))
        else $error("Charger one summary bit wrong");
    chk_sense_live: assert property (regRead && regAddr == ccir_pkg::CCIR_OFS_INPUT_SENSE
        |=> regReadData == {$past(senseLive), 1'b0})
        else $error("Sense register not live");
    chk_die_temp_set: assert property (statusCond.dieTemp[0] && !fullReset
        |=> statusFlags.dieTemp[0] [*1] ##0 statusPendingSummary)
        else $error("Die shutdown flag not raised");

endmodule : ccir_charger_ctrl_interrupt_regs

`default_nettype wire

// ### rtl/ccir_pkg.sv
// Constants and carrier types for the charger control and interrupt register bank
// Notes on behaviour
// - Bit 7 set disables watchdog; resets 0
// - Bit 6 set disables charge timer; resets 0
// - Bit 5 set enables power path; resets 0
// - Bit 4 transceiver supply; resets 1, survives OTG
// - Bit 3 set enables factory mode; resets 0
// - Bit 2: 1 pins, 0 registers; resets 1
// - Bit 1 applies four-bit input limit; resets 1
// - Bit 0 enables auto charge current; resets 0
// - Status flags bits 5..2 die temperature levels
// - Status bit 1 flags extended input range
// - Status bit 0 flags input in USB range
// - Charger one bit 4 flags charger detection
// - Charger one bit 3 flags input overvoltage
// - Charger one bit 2 flags battery removal
// - Charger one bit 1 flags battery overvoltage
// - Bit 0 of each summarises the other register
// - Charger two bits 7..4 battery temperature bands
// - Timer expiry flags, also cleared by timer reset
// - Boost flags bits 2..0, cleared entering charge
// - Sense bits 7..4 live input comparators
// - Sense bits 3..1 live detect and boost comparators
// - Off, power-on, software reset restore defaults
// - Pending summaries: status flags, fault flags
// - Global mask high blocks every interrupt
package ccir_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CCIR_OFS_CONTROL_TWO = 8'h02;
    localparam logic [7:0] CCIR_OFS_STATUS_INT = 8'h03;
    localparam logic [7:0] CCIR_OFS_CHARGER_ONE = 8'h04;
    localparam logic [7:0] CCIR_OFS_CHARGER_TWO = 8'h05;
    localparam logic [7:0] CCIR_OFS_BOOST_INT = 8'h06;
    localparam logic [7:0] CCIR_OFS_INPUT_SENSE = 8'h07;

    // ------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------
    typedef struct packed {
        logic watchdog_disable;
        logic charge_timer_disable;
        logic power_path_enable;
        logic transceiver_supply_on;
        logic factory_mode_enable;
        logic limit_source_pin_select;
        logic input_limit_enable;
        logic auto_charge_current_enable;
    } ccir_control_two_t;

    localparam ccir_control_two_t CCIR_CONTROL_TWO_RESET = 8'h16;
    // Only the transceiver supply survives OTG entry
    localparam ccir_control_two_t CCIR_CONTROL_TWO_OTG_KEEP = 8'h10;

    // Die temperature bits: warning, first, second, shutdown
    typedef struct packed {
        logic [3:0] dieTemp;
        logic extendedRange;
        logic usbRange;
    } ccir_status_t;

    typedef struct packed {
        logic chargerDetect;
        logic inputOvervoltage;
        logic batteryRemoved;
        logic batteryOvervoltage;
    } ccir_charger_one_t;

    // Battery temperature bits: hot, warm, chilly, cold
    typedef struct packed {
        logic [3:0] batteryTemp;
        logic watchdogExpired;
        logic usbTimerExpired;
        logic chargeTimerExpired;
    } ccir_charger_two_t;

    typedef struct packed {
        logic boostOverload;
        logic boostOvervoltage;
        logic boostLowBattery;
    } ccir_boost_t;

    typedef struct packed {
        logic inputLockout;
        logic extendedRange;
        logic usbOver;
        logic usbUnder;
        logic inputDetect;
        logic chargerOffset;
        logic boostUnder;
    } ccir_sense_t;

    localparam logic [7:0] CCIR_READ_ZERO = 8'h00;
    localparam logic [1:0] CCIR_PAD_TWO = 2'h0;
    localparam logic [2:0] CCIR_PAD_THREE = 3'h0;
    localparam logic [4:0] CCIR_PAD_FIVE = 5'h0;

endpackage : ccir_pkg
